// ---- core/hfh_framer.sv ----
/*
 HDLC framer between the host byte link and the modem line bit stream.
 Assumes line bit strobes and host bytes are synchronous to i_clk and
 that the host drains received words at least as fast as the line.
*/
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
// Notes on behaviour
// R1 - Framer builds and strips flags, CRC and stuffed zeros itself; received CRC bytes are passed to the host, not stripped.
// R2 - Host enables framing through the control bit before any call.
// R3 - On connection the device reports c, d or v to the host.
// R4 - With nothing pending the transmitter sends flags back to back.
// R5 - Host bytes are CRC accumulated and sent with zero insertion.
// R6 - Ninth host bit is an escape only when escape enable is set.
// R7 - Host sends one byte per CTS ready indication.
// R8 - Frame end is silence; device asserts CTS, host ignores that interrupt.
// R9 - Missing next byte ends the frame: CTS raised, CRC sent, closing flags.
// R10 - After the first closing flag CTS lowers for the next frame.
// R11 - Host should run its link faster than the line rate.
// R12 - Receiver hunts flags, starts CRC at first data, forwards destuffed bytes.
// R13 - Host receive rate is at least the line data rate.
// R14 - Only 8-bit words; ninth bit is escape in, result marker out.
// R15 - On closing flag last byte and both CRC bytes go out, then check.
// R16 - Result G for correct checksum, e for wrong.
// R17 - Seven or more ones abort the frame and send A.
// R18 - End-of-frame pin high with result words, only when pin selected.
// R19 - Ninth bit marks result words when both select bits are set.
// R20 - Next incoming frame lowers the end-of-frame pin again.
// R21 - Host checks the pin or ninth bit on every received byte.
// R22 - Retransmission and compression belong to the host.
// R23 - CRC is CCITT 16-bit, flag 01111110, zero after five ones.
`timescale 1ns/1ns
module hfh_framer
  import hfh_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_connected,
  input wire logic [1:0] i_connect_kind,
  input wire logic i_host_valid,
  input wire hfh_word_t i_host_word,
  output logic o_host_ready,
  output logic o_cts_n,
  output logic o_escape,
  output logic o_rx_valid,
  output hfh_word_t o_rx_word,
  output logic o_frame_end_result_pin,
  input wire logic i_tx_tick,
  output logic o_line_tx,
  input wire logic i_rx_tick,
  input wire logic i_rx_bit
);
  logic [HFH_CTRL_WIDTH-1:0] ctrl_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic conn_reg;
  logic reported_reg;
  logic hold_full_reg;
  logic [7:0] hold_reg;
  logic end_pending_reg;
  hfh_tx_state_t tx_state_reg;
  logic [7:0] tx_shift_reg;
  logic [2:0] tx_cnt_reg;
  logic [2:0] tx_ones_reg;
  logic rx_hunt_reg;
  logic rx_in_frame_reg;
  logic [2:0] rx_ones_reg;
  logic [2:0] rx_cnt_reg;
  logic [7:0] rx_shift_reg;
  logic frame_end_result_pin_reg;
  logic [7:0] good_cnt_reg;
  logic [7:0] err_cnt_reg;
  logic [7:0] abort_cnt_reg;
  logic [15:0] tx_crc;
  logic [15:0] rx_crc;
  logic frame_en;
  logic active;
  logic rx_active;
  logic bus_req;
  logic accept;
  logic escape_word;
  logic tx_stuffing;
  logic tx_stuff_now;
  logic tx_boundary;
  logic tx_take;
  logic tx_crc_init;
  logic rx_flag;
  logic rx_drop;
  logic rx_abort;
  logic rx_data_bit;
  logic rx_byte_done;
  logic [7:0] rx_byte;
  logic rx_result;
  logic [7:0] rx_result_chr;
  logic conn_event;
  logic [7:0] conn_chr;
  logic [31:0] rd_mux;

  // Register bus: one wait state, so read data are always registered
  assign bus_req = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = bus_req & ~ack_reg;
  assign o_avs_readdata = rdata_reg;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_avs_address)
      HFH_ADDR_CTRL: rd_mux[HFH_CTRL_WIDTH-1:0] = ctrl_reg;
      HFH_ADDR_STATUS: begin
        rd_mux[HFH_STAT_REPORTED] = reported_reg;
        rd_mux[HFH_STAT_TX_BUSY] = tx_state_reg != TX_FLAG;
        rd_mux[HFH_STAT_TX_END_PENDING] = end_pending_reg;
        rd_mux[HFH_STAT_RX_IN_FRAME] = rx_in_frame_reg;
        rd_mux[HFH_STAT_FRAME_END_RESULT_PIN] = frame_end_result_pin_reg;
      end
      HFH_ADDR_COUNT: rd_mux[23:0] = {abort_cnt_reg, err_cnt_reg, good_cnt_reg};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (i_avs_read & ~ack_reg) begin
      rdata_reg <= rd_mux;
    end
  end

  // R2 - framing enable written by host
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ctrl_reg <= HFH_CTRL_RESET;
    end else if (i_avs_write & ack_reg & i_avs_byteenable[0] &&
                 i_avs_address == HFH_ADDR_CTRL) begin
      ctrl_reg <= i_avs_writedata[HFH_CTRL_WIDTH-1:0];
    end
  end

  assign frame_en = ctrl_reg[HFH_CTRL_FRAME_MODE_ENABLE];
  assign active = frame_en & i_connected;
  assign rx_active = active & reported_reg;

  // R3 - connection report
  assign conn_event = frame_en & i_connected & ~conn_reg;
  assign conn_chr = (i_connect_kind == HFH_CONN_C) ? HFH_CHR_CONN_C :
                    (i_connect_kind == HFH_CONN_D) ? HFH_CHR_CONN_D : HFH_CHR_CONN_V;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      conn_reg <= 1'b0;
      reported_reg <= 1'b0;
    end else begin
      conn_reg <= i_connected & frame_en;
      reported_reg <= active & (reported_reg | conn_event);
    end
  end

  // R7 - CTS low means one byte may be sent
  assign o_host_ready = active & reported_reg & ~hold_full_reg & ~end_pending_reg;
  assign o_cts_n = ~o_host_ready;
  assign accept = i_host_valid & o_host_ready;
  // R6 - ninth bit only escapes in 9-bit format with escape enabled
  assign escape_word = i_host_word.ninth & ctrl_reg[HFH_CTRL_NINTH_BIT_ESCAPE_ENABLE] &
                       ctrl_reg[HFH_CTRL_DATA_FORMAT_SELECT];

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      hold_full_reg <= 1'b0;
      hold_reg <= 8'h00;
      o_escape <= 1'b0;
    end else begin
      // R14 - escaped words never framed
      o_escape <= accept & escape_word;
      if (!active) begin
        hold_full_reg <= 1'b0;
      end else if (accept & ~escape_word) begin
        hold_full_reg <= 1'b1;
        hold_reg <= i_host_word.data;
      end else if (tx_take) begin
        hold_full_reg <= 1'b0;
      end
    end
  end

  // R23 - stuffing only inside frame content, never in flags
  assign tx_stuffing = tx_state_reg == TX_DATA || tx_state_reg == TX_CRC_HI ||
                       tx_state_reg == TX_CRC_LO;
  // Counter only grows inside content, so a run ending the CRC still gets its zero
  assign tx_stuff_now = tx_ones_reg == HFH_STUFF_RUN;
  assign tx_boundary = i_tx_tick & ~tx_stuff_now & (tx_cnt_reg == HFH_LAST_BIT);
  assign tx_take = active & tx_boundary & hold_full_reg &
                   (tx_state_reg == TX_FLAG || tx_state_reg == TX_DATA);
  assign tx_crc_init = tx_state_reg == TX_FLAG;

  // R5 - CRC over every frame byte as it is loaded
  hfh_crc16 u_tx_crc (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_en(tx_take),
    .i_init(tx_crc_init),
    .i_data(hold_reg),
    .o_crc(tx_crc)
  );

  // R1 - transmit serializer with flag, CRC and stuffing
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !active) begin
      tx_state_reg <= TX_FLAG;
      tx_shift_reg <= HFH_FLAG;
      tx_cnt_reg <= 3'h0;
      tx_ones_reg <= 3'h0;
      o_line_tx <= 1'b1;
    end else if (i_tx_tick) begin
      if (tx_stuff_now) begin
        // R5 - inserted zero
        o_line_tx <= 1'b0;
        tx_ones_reg <= 3'h0;
      end else begin
        o_line_tx <= tx_shift_reg[7];
        tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
        tx_ones_reg <= (tx_stuffing & tx_shift_reg[7]) ? 3'(tx_ones_reg + 3'h1) : 3'h0;
        tx_cnt_reg <= 3'(tx_cnt_reg + 3'h1);
        if (tx_cnt_reg == HFH_LAST_BIT) begin
          case (tx_state_reg)
            TX_FLAG, TX_DATA: begin
              if (hold_full_reg) begin
                tx_state_reg <= TX_DATA;
                tx_shift_reg <= hold_reg;
              end else if (tx_state_reg == TX_DATA) begin
                // R9 - no byte waiting, close with CRC
                tx_state_reg <= TX_CRC_HI;
                tx_shift_reg <= tx_crc[15:8];
              end else begin
                // R4 - idle flags
                tx_shift_reg <= HFH_FLAG;
              end
            end
            TX_CRC_HI: begin
              tx_state_reg <= TX_CRC_LO;
              tx_shift_reg <= tx_crc[7:0];
            end
            TX_CRC_LO: begin
              tx_state_reg <= TX_CLOSE;
              tx_shift_reg <= HFH_FLAG;
            end
            TX_CLOSE: begin
              tx_state_reg <= TX_FLAG;
              tx_shift_reg <= HFH_FLAG;
            end
            default: begin
              tx_state_reg <= TX_FLAG;
              tx_shift_reg <= HFH_FLAG;
            end
          endcase
        end
      end
    end
  end

  // R8 - CTS held high from frame end until the first closing flag is out
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !active) begin
      end_pending_reg <= 1'b0;
    end else if (tx_boundary && tx_state_reg == TX_DATA && !hold_full_reg) begin
      end_pending_reg <= 1'b1;
    end else if (tx_boundary && tx_state_reg == TX_CLOSE) begin
      // R10 - ready for the next frame
      end_pending_reg <= 1'b0;
    end
  end

  // Receive bit classification
  assign rx_flag = rx_active & i_rx_tick & ~i_rx_bit & (rx_ones_reg == HFH_FLAG_RUN);
  assign rx_drop = rx_active & i_rx_tick & ~i_rx_bit & (rx_ones_reg == HFH_STUFF_RUN);
  assign rx_abort = rx_active & i_rx_tick & i_rx_bit & (rx_ones_reg == HFH_FLAG_RUN);
  assign rx_data_bit = rx_active & i_rx_tick & ~rx_flag & ~rx_drop & ~rx_abort &
                       ~rx_hunt_reg & (rx_ones_reg != HFH_ABORT_RUN);
  assign rx_byte_done = rx_data_bit && rx_cnt_reg == HFH_LAST_BIT;
  assign rx_byte = {rx_shift_reg[6:0], i_rx_bit};
  assign rx_result = (rx_flag | rx_abort) & rx_in_frame_reg;
  // R16 - checksum verdict
  assign rx_result_chr = rx_abort ? HFH_CHR_ABORT :
                         (rx_crc == HFH_CRC_RESIDUE) ? HFH_CHR_GOOD : HFH_CHR_ERROR;

  // R12 - CRC restarts at the first byte after a flag
  hfh_crc16 u_rx_crc (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_en(rx_byte_done),
    .i_init(~rx_in_frame_reg),
    .i_data(rx_byte),
    .o_crc(rx_crc)
  );

  // R12 - flag hunt and zero deletion
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !rx_active) begin
      rx_ones_reg <= 3'h0;
      rx_cnt_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_hunt_reg <= 1'b1;
      rx_in_frame_reg <= 1'b0;
    end else if (i_rx_tick) begin
      if (i_rx_bit) begin
        rx_ones_reg <= (rx_ones_reg == HFH_ABORT_RUN) ? rx_ones_reg : 3'(rx_ones_reg + 3'h1);
      end else begin
        rx_ones_reg <= 3'h0;
      end
      if (rx_flag) begin
        rx_hunt_reg <= 1'b0;
        rx_cnt_reg <= 3'h0;
        rx_in_frame_reg <= 1'b0;
      end else if (rx_abort) begin
        // R17 - abort forces a new hunt
        rx_hunt_reg <= 1'b1;
        rx_in_frame_reg <= 1'b0;
      end else if (rx_data_bit) begin
        rx_shift_reg <= rx_byte;
        rx_cnt_reg <= 3'(rx_cnt_reg + 3'h1);
        if (rx_byte_done) begin
          rx_in_frame_reg <= 1'b1;
        end
      end
    end
  end

  // Words toward the host; the connection report only precedes receive
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rx_valid <= 1'b0;
      o_rx_word <= '0;
    end else begin
      o_rx_valid <= conn_event | rx_result | rx_byte_done;
      if (conn_event) begin
        o_rx_word <= '{ninth: 1'b0, data: conn_chr};
      end else if (rx_result) begin
        // R19 - ninth bit marks result words
        o_rx_word.ninth <= ctrl_reg[HFH_CTRL_NINTH_BIT_FUNCTION_SELECT] &
                           ctrl_reg[HFH_CTRL_DATA_FORMAT_SELECT];
        o_rx_word.data <= rx_result_chr;
      end else if (rx_byte_done) begin
        // R15 - every byte, CRC bytes included, goes out as data
        o_rx_word <= '{ninth: 1'b0, data: rx_byte};
      end
    end
  end

  // R18 - end-of-frame level raised with the result word
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      frame_end_result_pin_reg <= 1'b0;
    end else if (rx_result) begin
      frame_end_result_pin_reg <= 1'b1;
    end else if (rx_byte_done & ~rx_in_frame_reg) begin
      // R20 - next frame lowers it
      frame_end_result_pin_reg <= 1'b0;
    end
  end
  assign o_frame_end_result_pin = frame_end_result_pin_reg & ctrl_reg[HFH_CTRL_PIN_ONE_FUNCTION_SELECT];

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      good_cnt_reg <= 8'h00;
      err_cnt_reg <= 8'h00;
      abort_cnt_reg <= 8'h00;
    end else if (rx_result) begin
      if (rx_abort) begin
        abort_cnt_reg <= 8'(abort_cnt_reg + 8'h01);
      end else if (rx_crc == HFH_CRC_RESIDUE) begin
        good_cnt_reg <= 8'(good_cnt_reg + 8'h01);
      end else begin
        err_cnt_reg <= 8'(err_cnt_reg + 8'h01);
      end
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_data_ends;
    active && tx_boundary && tx_state_reg == TX_DATA && !hold_full_reg;
  endsequence
  sequence s_crc_out;
    tx_state_reg == TX_CRC_HI && !o_host_ready;
  endsequence

  a_frame_end_crc: assert property (s_data_ends |=> s_crc_out) // R9
    else $error("frame end did not start CRC with CTS high");
  a_cts_release: assert property ($fell(end_pending_reg) && active |->
      tx_state_reg == TX_FLAG) // R10
    else $error("CTS released before closing flag");
  a_idle_no_stuff: assert property (tx_state_reg == TX_FLAG |-> !tx_stuff_now) // R4
    else $error("stuffing inside idle flags");
  a_zero_insert: assert property (active && i_tx_tick && tx_stuff_now |=>
      !o_line_tx && tx_ones_reg == 3'h0) // R5
    else $error("no zero after five ones");
  a_escape_drop: assert property (accept && escape_word |=> !hold_full_reg && o_escape) // R6
    else $error("escape word entered the frame");
  a_abort_char: assert property (rx_abort && rx_in_frame_reg |=>
      o_rx_valid && o_rx_word.data == HFH_CHR_ABORT) // R17
    else $error("abort not reported");
  a_good_char: assert property (rx_flag && rx_in_frame_reg && rx_crc == HFH_CRC_RESIDUE |=>
      o_rx_valid && o_rx_word.data == HFH_CHR_GOOD) // R16
    else $error("good frame not reported");
  a_frame_end_result_pin_with_result: assert property (rx_result &&
      ctrl_reg[HFH_CTRL_PIN_ONE_FUNCTION_SELECT] |=> o_frame_end_result_pin[*2]) // R18
    else $error("end-of-frame pin not raised");
  a_ninth_marks: assert property (o_rx_valid && o_rx_word.ninth |->
      ctrl_reg[HFH_CTRL_DATA_FORMAT_SELECT] && frame_end_result_pin_reg) // R19
    else $error("ninth bit on a data word");
  a_connect_report: assert property (conn_event |=> o_rx_valid && reported_reg) // R3
    else $error("connection not reported");
endmodule

// ---- common/hfh_pkg.sv ----
/*
 Shared constants and types for the HDLC framer with host byte link.
 Assumes a single clock domain; line bit strobes come from the modem data pump.
*/
package hfh_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] HFH_ADDR_CTRL = 4'h0;
  localparam logic [3:0] HFH_ADDR_STATUS = 4'h4;
  localparam logic [3:0] HFH_ADDR_COUNT = 4'h8;

  // Control register fields
  localparam int HFH_CTRL_FRAME_MODE_ENABLE = 0;
  localparam int HFH_CTRL_NINTH_BIT_ESCAPE_ENABLE = 1;
  localparam int HFH_CTRL_NINTH_BIT_FUNCTION_SELECT = 2;
  localparam int HFH_CTRL_DATA_FORMAT_SELECT = 3;
  localparam int HFH_CTRL_PIN_ONE_FUNCTION_SELECT = 4;
  localparam int HFH_CTRL_WIDTH = 5;
  localparam logic [HFH_CTRL_WIDTH-1:0] HFH_CTRL_RESET = 5'h00;

  // Status register fields
  localparam int HFH_STAT_REPORTED = 0;
  localparam int HFH_STAT_TX_BUSY = 1;
  localparam int HFH_STAT_TX_END_PENDING = 2;
  localparam int HFH_STAT_RX_IN_FRAME = 3;
  localparam int HFH_STAT_FRAME_END_RESULT_PIN = 4;

  // Line framing
  localparam logic [7:0] HFH_FLAG = 8'h7e;
  localparam logic [2:0] HFH_STUFF_RUN = 3'h5;
  localparam logic [2:0] HFH_FLAG_RUN = 3'h6;
  localparam logic [2:0] HFH_ABORT_RUN = 3'h7;
  localparam logic [2:0] HFH_LAST_BIT = 3'h7;
  localparam logic [15:0] HFH_CRC_POLY = 16'h1021;
  localparam logic [15:0] HFH_CRC_INIT = 16'hffff;
  localparam logic [15:0] HFH_CRC_RESIDUE = 16'h0000;

  // Characters sent to the host
  localparam logic [7:0] HFH_CHR_CONN_C = 8'h63;
  localparam logic [7:0] HFH_CHR_CONN_D = 8'h64;
  localparam logic [7:0] HFH_CHR_CONN_V = 8'h76;
  localparam logic [7:0] HFH_CHR_GOOD = 8'h47;
  localparam logic [7:0] HFH_CHR_ERROR = 8'h65;
  localparam logic [7:0] HFH_CHR_ABORT = 8'h41;

  // Connection kind reported by the call controller
  localparam logic [1:0] HFH_CONN_C = 2'h0;
  localparam logic [1:0] HFH_CONN_D = 2'h1;

  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } hfh_word_t;

  typedef enum {TX_FLAG, TX_DATA, TX_CRC_HI, TX_CRC_LO, TX_CLOSE} hfh_tx_state_t;
endpackage

// ---- core/hfh_crc16.sv ----
/*
 Byte-wide CCITT CRC accumulator, MSB first, no final inversion.
 Assumes the caller pulses i_en once per byte; i_init restarts from the seed.
*/
`timescale 1ns/1ns
module hfh_crc16
  import hfh_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_en,
  input wire logic i_init,
  input wire logic [7:0] i_data,
  output logic [15:0] o_crc
);
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[15] ^ d[i]) begin
        r = {r[14:0], 1'b0} ^ HFH_CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_crc <= HFH_CRC_INIT;
    end else if (i_en) begin
      o_crc <= crc_byte(i_init ? HFH_CRC_INIT : o_crc, i_data);
    end
  end
endmodule

// ---- test/hfh_host_model.sv ----
/*
 Host side model: offers words under CTS flow control and logs received words.
 Assumes it shares the framer clock and samples ready at the rising edge.
*/
`timescale 1ns/1ns
module hfh_host_model
  import hfh_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_cts_n,
  input wire logic i_escape,
  input wire logic i_rx_valid,
  input wire hfh_word_t i_rx_word,
  input wire logic i_frame_end_result_pin_pin,
  output logic o_host_valid,
  output hfh_word_t o_host_word
);
  logic [9:0] rxq[$];
  int esc_cnt = 0;

  initial begin
    o_host_valid = 1'b0;
    o_host_word = '0;
  end

  // one word per ready, offered at once
  // frame end is silence; a ready with no word behind it is ignored
  task automatic send(input hfh_word_t w, output bit ok);
    int n;
    ok = 0;
    @(posedge i_clk);
    o_host_valid <= 1'b1;
    o_host_word <= w;
    for (n = 0; n < 4000 && !ok; n++) begin
      @(posedge i_clk);
      ok = (i_cts_n === 1'b0);
    end
    o_host_valid <= 1'b0;
  endtask

  // retransmission and compression stay above this model, frames pass as given
  // no back-pressure; pin is logged with every word
  always @(posedge i_clk) begin
    if (i_rx_valid === 1'b1)
      rxq.push_back({i_frame_end_result_pin_pin, i_rx_word});
    if (i_escape === 1'b1)
      esc_cnt++;
  end
endmodule

// ---- test/hfh_framer_test.sv ----
/*
 Self-checking bench for the framer: register bus, connect report, loopback frames.
 Assumes the host model file; the line is looped back or driven by the bench.
*/
`timescale 1ns/1ns
module hfh_framer_test;
  import hfh_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] av_addr = 4'h0;
  logic [3:0] av_be = 4'h0;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wdata = 32'h0;
  logic [31:0] av_rdata;
  logic av_wait;
  logic connected = 1'b0;
  logic [1:0] conn_kind = 2'h0;
  logic host_valid, host_ready, cts_n, escape, rx_valid, frame_end_result_pin_pin, line_tx;
  hfh_word_t host_word, rx_word;
  logic tx_tick = 1'b0;
  logic rx_tick = 1'b0;
  logic loop_on = 1'b1;
  logic drv_bit = 1'b1;
  logic [2:0] tick_cnt = 3'h0;
  logic bit_q[$];
  int failures = 0;
  int n_tests = 0;
  logic [31:0] rd;
  logic [23:0] sh;
  logic found;
  bit ok;
  logic [1:0] kinds[3] = '{HFH_CONN_C, 2'h2, HFH_CONN_D};
  logic [7:0] chars[3] = '{HFH_CHR_CONN_C, HFH_CHR_CONN_V, HFH_CHR_CONN_D};

  always #50 i_clk = ~i_clk;

  hfh_framer uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(av_addr),
    .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_byteenable(av_be),
    .i_avs_writedata(av_wdata), .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait),
    .i_connected(connected), .i_connect_kind(conn_kind), .i_host_valid(host_valid),
    .i_host_word(host_word), .o_host_ready(host_ready), .o_cts_n(cts_n),
    .o_escape(escape), .o_rx_valid(rx_valid), .o_rx_word(rx_word),
    .o_frame_end_result_pin(frame_end_result_pin_pin), .i_tx_tick(tx_tick), .o_line_tx(line_tx),
    .i_rx_tick(rx_tick), .i_rx_bit(loop_on ? line_tx : drv_bit));

  hfh_host_model u_host (.i_clk(i_clk), .i_cts_n(cts_n), .i_escape(escape),
    .i_rx_valid(rx_valid), .i_rx_word(rx_word), .i_frame_end_result_pin_pin(frame_end_result_pin_pin),
    .o_host_valid(host_valid), .o_host_word(host_word));

  function automatic void push_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      bit_q.push_back(b[i]);
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
      r = {r[14:0], 1'b0} ^ ((r[15] ^ b[i]) ? HFH_CRC_POLY : 16'h0000);
    return r;
  endfunction

  // Bit strobes every 8 clocks; the receiver samples mid-bit, idle bench line sends flags
  always @(posedge i_clk) begin
    tick_cnt <= tick_cnt + 3'h1;
    tx_tick <= (tick_cnt == 3'h7);
    rx_tick <= (tick_cnt == 3'h3);
    if (tick_cnt == 3'h1) begin
      if (bit_q.size() == 0)
        push_byte(HFH_FLAG);
      drv_bit <= bit_q.pop_front();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic timeout(input string what);
    failures++;
    $display("MISMATCH %s expected answer seen timeout", what);
    complete_run();
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [3:0] be,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge i_clk);
    av_addr <= a;
    av_be <= be;
    av_wdata <= d;
    av_wr <= wr;
    av_rd <= ~wr;
    for (n = 0; n < 50; n++) begin
      @(posedge i_clk);
      if (av_wait === 1'b0)
        break;
    end
    if (n == 50)
      timeout("bus");
    q = av_rdata;
    av_rd <= 1'b0;
    av_wr <= 1'b0;
  endtask

  task automatic hsend(input hfh_word_t w);
    u_host.send(w, ok);
    if (!ok)
      timeout("host send");
  endtask

  task automatic expect_rx(input string what, input logic [9:0] exp);
    int n;
    for (n = 0; n < 3000 && u_host.rxq.size() == 0; n++)
      @(posedge i_clk);
    if (n == 3000)
      timeout(what);
    check(what, {22'h0, u_host.rxq.pop_front()}, {22'h0, exp});
  endtask

  // Two-word frame over the loopback; expect data, CRC high first, then the result
  task automatic frame(input hfh_word_t w0, input hfh_word_t w1, input logic [9:0] res);
    logic [15:0] c;
    c = crc_step(crc_step(HFH_CRC_INIT, w0.data), w1.data);
    hsend(w0);
    hsend(w1);
    expect_rx("data0", {2'b00, w0.data});
    expect_rx("data1", {2'b00, w1.data});
    expect_rx("crc hi", {2'b00, c[15:8]});
    check("cts at end", cts_n, 1'b1);
    expect_rx("crc lo", {2'b00, c[7:0]});
    expect_rx("result", res);
    repeat (16) @(posedge i_clk);
    check("cts next", cts_n, 1'b0);
  endtask

  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    bus(1'b0, HFH_ADDR_CTRL, 4'hf, 32'h0, rd);
    check("ctrl reset", rd, {27'h0, HFH_CTRL_RESET});
    bus(1'b1, HFH_ADDR_CTRL, 4'h1, 32'h1d, rd);
    bus(1'b1, HFH_ADDR_CTRL, 4'h0, 32'h0, rd);
    bus(1'b1, HFH_ADDR_STATUS, 4'hf, 32'hff, rd);
    bus(1'b0, HFH_ADDR_CTRL, 4'hf, 32'h0, rd);
    check("ctrl", rd, 32'h1d);
    bus(1'b0, 4'hc, 4'hf, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    for (int k = 0; k < 3; k++) begin
      @(posedge i_clk);
      conn_kind <= kinds[k];
      connected <= 1'b1;
      expect_rx("connect", {2'b00, chars[k]});
      if (k < 2) begin
        @(posedge i_clk);
        connected <= 1'b0;
        repeat (20) @(posedge i_clk);
      end
    end
    for (int i = 0; i < 24; i++) begin
      @(posedge i_clk);
      for (int w = 0; w < 16 && rx_tick !== 1'b1; w++)
        @(posedge i_clk);
      if (rx_tick !== 1'b1)
        timeout("line tick");
      sh = {sh[22:0], line_tx};
    end
    found = 1'b0;
    for (int o = 0; o <= 8; o++)
      if (sh[o+:16] === 16'h7e7e)
        found = 1'b1;
    check("idle flags", found, 1'b1);
    frame('{1'b0, 8'hff}, '{1'b1, 8'h00}, {2'b11, HFH_CHR_GOOD});
    bus(1'b1, HFH_ADDR_CTRL, 4'h1, 32'h19, rd);
    frame('{1'b0, 8'h5a}, '{1'b0, 8'h3c}, {2'b10, HFH_CHR_GOOD});
    bus(1'b1, HFH_ADDR_CTRL, 4'h1, 32'h09, rd);
    loop_on <= 1'b0;
    repeat (400) @(posedge i_clk);
    u_host.rxq.delete();
    push_byte(HFH_FLAG);
    push_byte(8'h12);
    push_byte(8'hff);
    push_byte(8'hff);
    expect_rx("abort data", {2'b00, 8'h12});
    expect_rx("abort", {2'b00, HFH_CHR_ABORT});
    bus(1'b1, HFH_ADDR_CTRL, 4'h1, 32'h1d, rd);
    push_byte(HFH_FLAG);
    push_byte(8'h12);
    push_byte(8'h34);
    push_byte(8'h56);
    push_byte(HFH_FLAG);
    expect_rx("bad data", {2'b00, 8'h12});
    expect_rx("bad crc hi", {2'b00, 8'h34});
    expect_rx("bad crc lo", {2'b00, 8'h56});
    expect_rx("error", {2'b11, HFH_CHR_ERROR});
    check("no escape", u_host.esc_cnt, 32'h0);
    bus(1'b1, HFH_ADDR_CTRL, 4'h1, 32'h1f, rd);
    hsend('{1'b1, 8'h2b});
    repeat (4) @(posedge i_clk);
    check("escape", u_host.esc_cnt, 32'h1);
    bus(1'b0, HFH_ADDR_STATUS, 4'hf, 32'h0, rd);
    check("status", rd, (32'h1 << HFH_STAT_REPORTED) | (32'h1 << HFH_STAT_FRAME_END_RESULT_PIN));
    bus(1'b0, HFH_ADDR_COUNT, 4'hf, 32'h0, rd);
    check("good count", {24'h0, rd[7:0]}, 32'h2);
    complete_run();
  end
endmodule
